/* rtl/i2cm_pkg.sv */
// constants for the two-wire master start and reservation block
// Operation
// - Low width register sets clock low time and paces data line changes.
// - Low width register resets to all ones.
// - Data held after clock falls for one quarter of low width.
// - Reservation works only while reservation-disable flag is zero.
// - Bus counts unused after reset, after a stop, or when released by exit bit.
// - Start request on an unused bus after stop makes start, then wait.
// - Start request: start at once if bus free, else reserve and stand by.
// - Stop detection with stop interrupt enabled raises transfer interrupt.
// - Shift write after stop interrupt starts communication as master.
// - Shift writes before a stop is detected are discarded.
package i2cm_pkg;
	// register indices on the cpu port
	localparam int ADDR_W = 3;
	localparam logic [2:0] IDX_LOW_WIDTH = 3'h0;
	localparam logic [2:0] IDX_HIGH_WIDTH = 3'h1;
	localparam logic [2:0] IDX_CTL0 = 3'h2;
	localparam logic [2:0] IDX_FLAG = 3'h3;
	localparam logic [2:0] IDX_STATUS = 3'h4;
	localparam logic [2:0] IDX_SHIFT = 3'h5;
	// control register 0 fields
	localparam int CTL0_ENABLE_BIT = 7;
	localparam int CTL0_EXIT_BIT = 6;
	localparam int CTL0_STOP_IE_BIT = 4;
	localparam int CTL0_START_BIT = 1;
	// flag register fields
	localparam int FLAG_RSV_DIS_BIT = 0;
	// status register fields
	localparam int STAT_MASTER_BIT = 7;
	localparam int STAT_RESERVED_BIT = 5;
	localparam int STAT_STOP_SEEN_BIT = 4;
	localparam int STAT_CLK_LVL_BIT = 3;
	localparam int STAT_DAT_LVL_BIT = 2;
	// values after reset
	localparam logic [7:0] LOW_WIDTH_RST = 8'hFF;
	localparam logic [7:0] HIGH_WIDTH_RST = 8'hFF;
	localparam logic [7:0] CTL0_RST = 8'h00;
	localparam logic [7:0] FLAG_RST = 8'h00;
	localparam logic [7:0] SHIFT_RST = 8'h00;
	// frame shape, hold divider and synchroniser width
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam int HOLD_SHIFT = 2;
	localparam int SYNC_STAGES = 2;
endpackage : i2cm_pkg

/* rtl/i2cm_sync.sv */
// two flip-flop synchroniser for the bus line inputs
`timescale 1ns/1ps
module i2cm_sync #(
	parameter int W = 2
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// asynchronous in, synchronised out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] meta_next;
	logic [W-1:0] q_next;

	// idle bus level is high, so reset to ones
	always_comb begin
		meta_next = d;
		q_next = meta_reg;
	end

	// first stage is read only by the second
	always_ff @(posedge clk) begin
		if (srst) begin
			meta_reg <= '1;
			q <= '1;
		end else begin
			meta_reg <= meta_next;
			q <= q_next;
		end
	end
endmodule : i2cm_sync

/* rtl/i2cm_master.sv */
// two-wire master: clock widths, start generation and reservation
`timescale 1ns/1ps
module i2cm_master (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// cpu register port
	input wire logic [i2cm_pkg::ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// serial clock pin, open drain
	input wire logic serial_clock_pin_in,
	output logic serial_clock_pin_out,
	output logic serial_clock_pin_oe_n,
	// serial data pin, open drain
	input wire logic serial_data_pin_in,
	output logic serial_data_pin_out,
	output logic serial_data_pin_oe_n,
	// interrupt request
	output logic transfer_interrupt_request
);
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RESERVE,
		ST_START,
		ST_WAIT,
		ST_LOW,
		ST_HIGH
	} i2cm_state_e;

	logic [1:0] line_sync;
	logic scl_s;
	logic sda_s;

	i2cm_sync #(
		.W(i2cm_pkg::SYNC_STAGES)
	) u_sync (
		.clk(clk),
		.srst(srst),
		.d({serial_clock_pin_in, serial_data_pin_in}),
		.q(line_sync)
	);

	assign scl_s = line_sync[1];
	assign sda_s = line_sync[0];

	i2cm_state_e state_reg, state_next;
	logic [7:0] scl_low_width_reg, scl_low_width_next;
	logic [7:0] scl_high_width_reg, scl_high_width_next;
	logic [7:0] control_register_0_reg, control_register_0_next;
	logic [7:0] bus_flag_register_reg, bus_flag_register_next;
	logic [7:0] bus_shift_register_reg, bus_shift_register_next;
	logic [7:0] cnt_reg, cnt_next;
	logic [3:0] bitcnt_reg, bitcnt_next;
	logic sda_prev_reg, sda_prev_next;
	logic busy_reg, busy_next;
	logic stop_seen_reg, stop_seen_next;
	logic master_reg, master_next;
	logic reserved_reg, reserved_next;
	logic have_byte_reg, have_byte_next;
	logic scl_oe_n_reg, scl_oe_n_next;
	logic sda_oe_n_reg, sda_oe_n_next;
	logic irq_reg, irq_next;
	logic [7:0] rdata_reg, rdata_next;

	logic start_det;
	logic stop_det;
	logic ctl_wr;
	logic start_req;
	logic exit_req;
	logic shift_wr;
	logic enabled;
	logic rsv_enabled;
	logic [7:0] hold_cnt;
	logic [7:0] status_val;

	// line events seen on the synchronised levels
	assign start_det = scl_s & sda_prev_reg & ~sda_s;
	assign stop_det = scl_s & ~sda_prev_reg & sda_s;

	// register write decode
	assign ctl_wr = reg_wr && (reg_addr == i2cm_pkg::IDX_CTL0);
	assign shift_wr = reg_wr && (reg_addr == i2cm_pkg::IDX_SHIFT);
	assign enabled = control_register_0_reg[i2cm_pkg::CTL0_ENABLE_BIT];
	assign start_req = ctl_wr & reg_wdata[i2cm_pkg::CTL0_START_BIT] & enabled;
	assign exit_req = ctl_wr & reg_wdata[i2cm_pkg::CTL0_EXIT_BIT];
	assign rsv_enabled = ~bus_flag_register_reg[i2cm_pkg::FLAG_RSV_DIS_BIT];

	// data changes a quarter of the low time after the clock falls
	assign hold_cnt = scl_low_width_reg >> i2cm_pkg::HOLD_SHIFT;

	// status view of the block's own state and the line levels
	always_comb begin
		status_val = 8'h00;
		status_val[i2cm_pkg::STAT_MASTER_BIT] = master_reg;
		status_val[i2cm_pkg::STAT_RESERVED_BIT] = reserved_reg;
		status_val[i2cm_pkg::STAT_STOP_SEEN_BIT] = stop_seen_reg;
		status_val[i2cm_pkg::STAT_CLK_LVL_BIT] = scl_s;
		status_val[i2cm_pkg::STAT_DAT_LVL_BIT] = sda_s;
	end

	// next state of registers, bus tracking and the line sequencer
	always_comb begin
		state_next = state_reg;
		scl_low_width_next = scl_low_width_reg;
		scl_high_width_next = scl_high_width_reg;
		control_register_0_next = control_register_0_reg;
		bus_flag_register_next = bus_flag_register_reg;
		bus_shift_register_next = bus_shift_register_reg;
		cnt_next = cnt_reg;
		bitcnt_next = bitcnt_reg;
		sda_prev_next = sda_s;
		busy_next = busy_reg;
		stop_seen_next = stop_seen_reg;
		master_next = master_reg;
		reserved_next = reserved_reg;
		have_byte_next = have_byte_reg;
		scl_oe_n_next = scl_oe_n_reg;
		sda_oe_n_next = sda_oe_n_reg;
		irq_next = stop_det & control_register_0_reg[i2cm_pkg::CTL0_STOP_IE_BIT];

		// plain register writes; width writes are not blocked while enabled
		if (reg_wr) begin
			unique case (reg_addr)
				i2cm_pkg::IDX_LOW_WIDTH: scl_low_width_next = reg_wdata;
				i2cm_pkg::IDX_HIGH_WIDTH: scl_high_width_next = reg_wdata;
				i2cm_pkg::IDX_FLAG: bus_flag_register_next = reg_wdata;
				i2cm_pkg::IDX_CTL0: begin
					// start and exit bits are actions, never stored
					control_register_0_next = reg_wdata;
					control_register_0_next[i2cm_pkg::CTL0_START_BIT] = 1'b0;
					control_register_0_next[i2cm_pkg::CTL0_EXIT_BIT] = 1'b0;
				end
				default: ;
			endcase
		end

		// bus occupancy; a stop in the same cycle as a start wins
		if (start_det) begin
			busy_next = 1'b1;
			stop_seen_next = 1'b0;
		end
		if (stop_det) begin
			busy_next = 1'b0;
			stop_seen_next = 1'b1;
			master_next = 1'b0;
		end

		unique case (state_reg)
			ST_IDLE: begin
				scl_oe_n_next = 1'b1;
				sda_oe_n_next = 1'b1;
				if (start_req) begin
					if (!busy_reg) begin
						state_next = ST_START;
						cnt_next = 8'h00;
					end else if (rsv_enabled) begin
						state_next = ST_RESERVE;
						reserved_next = 1'b1;
					end
				end else if (shift_wr && stop_seen_reg && !busy_reg && enabled) begin
					bus_shift_register_next = reg_wdata;
					have_byte_next = 1'b1;
					state_next = ST_START;
					cnt_next = 8'h00;
				end
			end
			ST_RESERVE: begin
				// stand by, lines released, until the bus owner stops
				if (stop_det) begin
					reserved_next = 1'b0;
					state_next = ST_START;
					cnt_next = 8'h00;
				end
			end
			ST_START: begin
				// data low while clock stays released: start condition
				sda_oe_n_next = 1'b0;
				scl_oe_n_next = 1'b1;
				master_next = 1'b1;
				if (shift_wr) begin
					bus_shift_register_next = reg_wdata;
					have_byte_next = 1'b1;
				end
				if (cnt_reg >= scl_high_width_reg) begin
					scl_oe_n_next = 1'b0;
					cnt_next = 8'h00;
					bitcnt_next = 4'h0;
					state_next = (have_byte_reg || shift_wr) ? ST_LOW : ST_WAIT;
				end else begin
					cnt_next = cnt_reg + 8'h01;
				end
			end
			ST_WAIT: begin
				// clock held low as a wait until software loads a byte
				scl_oe_n_next = 1'b0;
				if (shift_wr) begin
					bus_shift_register_next = reg_wdata;
					have_byte_next = 1'b1;
					bitcnt_next = 4'h0;
					cnt_next = 8'h00;
					state_next = ST_LOW;
				end
			end
			ST_LOW: begin
				scl_oe_n_next = 1'b0;
				if (cnt_reg == hold_cnt) begin
					// ack slot releases data for the receiver
					if (bitcnt_reg < i2cm_pkg::BITS_PER_BYTE) begin
						sda_oe_n_next = bus_shift_register_reg[7];
					end else begin
						sda_oe_n_next = 1'b1;
					end
				end
				if (cnt_reg >= scl_low_width_reg) begin
					scl_oe_n_next = 1'b1;
					cnt_next = 8'h00;
					state_next = ST_HIGH;
				end else begin
					cnt_next = cnt_reg + 8'h01;
				end
			end
			ST_HIGH: begin
				// a slave stretching the clock pauses the high count
				scl_oe_n_next = 1'b1;
				if (scl_s) begin
					if (cnt_reg >= scl_high_width_reg) begin
						scl_oe_n_next = 1'b0;
						cnt_next = 8'h00;
						if (bitcnt_reg == i2cm_pkg::BITS_PER_BYTE) begin
							have_byte_next = 1'b0;
							state_next = ST_WAIT;
						end else begin
							bus_shift_register_next = {bus_shift_register_reg[6:0], sda_s};
							bitcnt_next = bitcnt_reg + 4'h1;
							state_next = ST_LOW;
						end
					end else begin
						cnt_next = cnt_reg + 8'h01;
					end
				end
			end
		endcase

		// shift writes outside a valid window fall away here
		if (shift_wr && !stop_seen_reg && !master_reg && state_reg != ST_START) begin
			bus_shift_register_next = bus_shift_register_reg;
			have_byte_next = have_byte_reg;
		end

		// exit bit or disable drops everything and releases the lines; only the exit bit marks the bus free
		if (exit_req || !enabled) begin
			busy_next = exit_req ? 1'b0 : busy_next;
			stop_seen_next = exit_req ? 1'b1 : stop_seen_next;
			master_next = 1'b0;
			reserved_next = 1'b0;
			have_byte_next = 1'b0;
			scl_oe_n_next = 1'b1;
			sda_oe_n_next = 1'b1;
			state_next = ST_IDLE;
		end
	end

	// registered read data, one cycle behind the address
	always_comb begin
		unique case (reg_addr)
			i2cm_pkg::IDX_LOW_WIDTH: rdata_next = scl_low_width_reg;
			i2cm_pkg::IDX_HIGH_WIDTH: rdata_next = scl_high_width_reg;
			i2cm_pkg::IDX_CTL0: rdata_next = control_register_0_reg;
			i2cm_pkg::IDX_FLAG: rdata_next = bus_flag_register_reg;
			i2cm_pkg::IDX_STATUS: rdata_next = status_val;
			i2cm_pkg::IDX_SHIFT: rdata_next = bus_shift_register_reg;
			default: rdata_next = 8'h00;
		endcase
	end

	// state registers
	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg <= ST_IDLE;
			scl_low_width_reg <= i2cm_pkg::LOW_WIDTH_RST;
			scl_high_width_reg <= i2cm_pkg::HIGH_WIDTH_RST;
			control_register_0_reg <= i2cm_pkg::CTL0_RST;
			bus_flag_register_reg <= i2cm_pkg::FLAG_RST;
			bus_shift_register_reg <= i2cm_pkg::SHIFT_RST;
			cnt_reg <= 8'h00;
			bitcnt_reg <= 4'h0;
			sda_prev_reg <= 1'b1;
			busy_reg <= 1'b0;
			stop_seen_reg <= 1'b0;
			master_reg <= 1'b0;
			reserved_reg <= 1'b0;
			have_byte_reg <= 1'b0;
			scl_oe_n_reg <= 1'b1;
			sda_oe_n_reg <= 1'b1;
			irq_reg <= 1'b0;
			rdata_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			scl_low_width_reg <= scl_low_width_next;
			scl_high_width_reg <= scl_high_width_next;
			control_register_0_reg <= control_register_0_next;
			bus_flag_register_reg <= bus_flag_register_next;
			bus_shift_register_reg <= bus_shift_register_next;
			cnt_reg <= cnt_next;
			bitcnt_reg <= bitcnt_next;
			sda_prev_reg <= sda_prev_next;
			busy_reg <= busy_next;
			stop_seen_reg <= stop_seen_next;
			master_reg <= master_next;
			reserved_reg <= reserved_next;
			have_byte_reg <= have_byte_next;
			scl_oe_n_reg <= scl_oe_n_next;
			sda_oe_n_reg <= sda_oe_n_next;
			irq_reg <= irq_next;
			rdata_reg <= rdata_next;
		end
	end

	// open drain: the pin value is always low, enable decides
	assign serial_clock_pin_out = 1'b0;
	assign serial_data_pin_out = 1'b0;
	assign serial_clock_pin_oe_n = scl_oe_n_reg;
	assign serial_data_pin_oe_n = sda_oe_n_reg;
	assign transfer_interrupt_request = irq_reg;
	assign reg_rdata = rdata_reg;
endmodule : i2cm_master

/* tb/i2cm_assertions.sv */
// checker for the two-wire master clock widths, start and stop interrupt
`timescale 1ns/1ps
module i2cm_assertions (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// register port
	input wire logic [i2cm_pkg::ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	// line levels and drives
	input wire logic serial_clock_pin_in,
	input wire logic serial_clock_pin_oe_n,
	input wire logic serial_data_pin_in,
	input wire logic serial_data_pin_oe_n,
	// interrupt
	input wire logic transfer_interrupt_request
);
	logic [7:0] lw_reg, hw_reg;
	logic [15:0] lo_reg, st_reg, sp_reg;
	logic on_reg, sdo_reg, sdi_reg;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// width mirror plus low, start and stop-age counters; run is short, no wrap
	always_ff @(posedge clk) begin
		if (srst) begin
			lw_reg <= i2cm_pkg::LOW_WIDTH_RST;
			hw_reg <= i2cm_pkg::HIGH_WIDTH_RST;
			lo_reg <= 16'h0000;
			st_reg <= 16'h0000;
			sp_reg <= 16'h00FF;
			on_reg <= 1'b0;
			sdo_reg <= 1'b1;
			sdi_reg <= 1'b1;
		end else begin
			if (reg_wr && reg_addr == i2cm_pkg::IDX_LOW_WIDTH) lw_reg <= reg_wdata;
			if (reg_wr && reg_addr == i2cm_pkg::IDX_HIGH_WIDTH) hw_reg <= reg_wdata;
			lo_reg <= serial_clock_pin_oe_n ? 16'h0000 : lo_reg + 16'h0001;
			st_reg <= (sdo_reg && !serial_data_pin_oe_n) ? 16'h0001 : st_reg + 16'h0001;
			sp_reg <= (serial_clock_pin_in && !sdi_reg && serial_data_pin_in) ? 16'h0000
				: sp_reg + 16'h0001;
			sdo_reg <= serial_data_pin_oe_n;
			sdi_reg <= serial_data_pin_in;
			if (!serial_clock_pin_oe_n) on_reg <= 1'b0;
			else if (sdo_reg && !serial_data_pin_oe_n) on_reg <= 1'b1;
		end
	end
	sequence s_lw_write;
		reg_wr && reg_addr == i2cm_pkg::IDX_LOW_WIDTH;
	endsequence
	sequence s_lw_read;
		!reg_wr && reg_addr == i2cm_pkg::IDX_LOW_WIDTH;
	endsequence
	a_width_readback: assert property (s_lw_write ##1 s_lw_read |=> reg_rdata == $past(reg_wdata, 2))
		else $error("low width readback wrong");
	a_clock_low_width: assert property ($rose(serial_clock_pin_oe_n) && lo_reg <= 16'(lw_reg) + 16'h0002
		|-> lo_reg == 16'(lw_reg) + 16'h0001) else $error("clock low width wrong");
	a_data_hold: assert property (!serial_clock_pin_oe_n && $changed(serial_data_pin_oe_n)
		&& lo_reg <= 16'(lw_reg) |-> lo_reg >= 16'(lw_reg >> 2) && lo_reg <= 16'(lw_reg >> 2) + 16'h0001)
		else $error("data hold not a quarter of low width");
	// data falls one edge after entering start, clock falls at the high-width count
	a_start_high: assert property ($fell(serial_clock_pin_oe_n) && on_reg |-> st_reg == 16'(hw_reg))
		else $error("start held wrong time before clock low");
	a_irq_after_stop: assert property (transfer_interrupt_request |-> sp_reg >= 16'h0002 && sp_reg <= 16'h0006)
		else $error("interrupt without a recent stop");
	a_irq_one_pulse: assert property ($rose(transfer_interrupt_request) |=> !transfer_interrupt_request)
		else $error("interrupt longer than one cycle");
	a_disable_release: assert property (reg_wr && reg_addr == i2cm_pkg::IDX_CTL0 && !reg_wdata[7]
		|-> ##2 (serial_clock_pin_oe_n && serial_data_pin_oe_n)[*2]) else $error("disable left lines driven");
	a_exit_release: assert property (reg_wr && reg_addr == i2cm_pkg::IDX_CTL0 && reg_wdata[6]
		|-> ##2 serial_clock_pin_oe_n && serial_data_pin_oe_n) else $error("exit left lines driven");
endmodule : i2cm_assertions

/* tb/i2cm_bus_model.sv */
// other master and listening slave on the two-wire bus
`timescale 1ns/1ps
module i2cm_bus_model (
	// resolved lines
	input wire logic scl,
	input wire logic sda,
	// open-drain drive, low pulls the line
	output logic scl_oe_n,
	output logic sda_oe_n,
	// last byte heard
	output logic [7:0] rx_byte
);
	int nbits = 0;
	initial begin
		scl_oe_n = 1'b1;
		sda_oe_n = 1'b1;
		rx_byte = 8'h00;
	end
	// any start restarts the byte; bits taken on clock rise
	always @(negedge sda) if (scl === 1'b1) nbits = 0;
	always @(posedge scl) begin
		if (nbits < 8) rx_byte = {rx_byte[6:0], sda};
		nbits++;
	end
	// start and two bits leave the bus busy, device neither master nor slave
	task automatic open_frame();
		sda_oe_n = 1'b0;
		#100;
		repeat (2) begin
			scl_oe_n = 1'b0;
			#50 sda_oe_n = 1'($urandom);
			#50 scl_oe_n = 1'b1;
			#100;
		end
	endtask : open_frame
	// stuck slave holds data low; clock pulses until it lets go
	task automatic free_data(input int n);
		sda_oe_n = 1'b0;
		#100;
		while (sda !== 1'b1) begin
			scl_oe_n = 1'b0;
			#100 scl_oe_n = 1'b1;
			n--;
			#50;
			if (n <= 0) sda_oe_n = 1'b1;
			#50;
		end
	endtask : free_data
	// stop: data rises while clock is high, releasing the bus
	task automatic close_frame();
		scl_oe_n = 1'b0;
		#50 sda_oe_n = 1'b0;
		#50 scl_oe_n = 1'b1;
		#100 sda_oe_n = 1'b1;
	endtask : close_frame
endmodule : i2cm_bus_model

/* tb/testbench.sv */
// self-checking bench for the two-wire master block
`timescale 1ns/1ps
module testbench;
	logic clk, srst, reg_wr, rd_go, rd_q, scl_oe_n, sda_oe_n, m_scl_oe_n, m_sda_oe_n, irq;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, lw, hw, rx_byte;
	logic [15:0] exp_q[$];
	logic [15:0] exp_note;
	int mismatches = 0, cmp_count = 0, irqs = 0, cyc = 0;
	wire scl = scl_oe_n & m_scl_oe_n; // lines pulled up
	wire sda = sda_oe_n & m_sda_oe_n;
	i2cm_master dut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .serial_clock_pin_in(scl),
		.serial_clock_pin_out(), .serial_clock_pin_oe_n(scl_oe_n), .serial_data_pin_in(sda),
		.serial_data_pin_out(), .serial_data_pin_oe_n(sda_oe_n),
		.transfer_interrupt_request(irq));
	i2cm_bus_model bus (.scl(scl), .sda(sda), .scl_oe_n(m_scl_oe_n), .sda_oe_n(m_sda_oe_n),
		.rx_byte(rx_byte));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic print_verdict();
		if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask : wr
	// read note: mask in the upper byte, expected value in the lower
	task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
		@(negedge clk);
		reg_addr = a;
		exp_q.push_back({m, e});
		rd_go = 1'b1;
		@(negedge clk);
		rd_go = 0;
	endtask : rd
	// read data is registered: compare one edge after the address was taken
	always @(posedge clk) rd_q <= rd_go;
	always @(negedge clk) begin
		if (rd_q === 1'b1) begin
			exp_note = exp_q.pop_front();
			chk(reg_rdata & exp_note[15:8], exp_note[7:0]);
		end
		if (irq === 1'b1) irqs++;
	end
	// hang guard, far above the several hundred cycles used
	always @(posedge clk) begin
		cyc++;
		if (cyc > 5000) begin
			mismatches++;
			print_verdict();
		end
	end
	initial begin
		void'($urandom(32'h94F6ADB2));
		srst = 1'b1;
		reg_wr = 1'b0;
		rd_go = 1'b0;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		repeat (16) @(negedge clk);
		srst = 1'b0;
		rd(i2cm_pkg::IDX_LOW_WIDTH, 8'hFF, i2cm_pkg::LOW_WIDTH_RST);
		rd(3'h6, 8'hFF, 8'h00);
		lw = 8'($urandom);
		wr(i2cm_pkg::IDX_LOW_WIDTH, lw);
		rd(i2cm_pkg::IDX_LOW_WIDTH, 8'hFF, lw);
		lw = 8'h0B;
		hw = 8'($urandom_range(12, 4));
		wr(i2cm_pkg::IDX_LOW_WIDTH, lw);
		wr(i2cm_pkg::IDX_HIGH_WIDTH, hw);
		wr(i2cm_pkg::IDX_CTL0, 8'h90);
		bus.open_frame();
		wr(i2cm_pkg::IDX_SHIFT, 8'h3C);
		rd(i2cm_pkg::IDX_SHIFT, 8'hFF, i2cm_pkg::SHIFT_RST);
		wr(i2cm_pkg::IDX_CTL0, 8'h92);
		rd(i2cm_pkg::IDX_STATUS, 8'hA0, 8'h20);
		bus.close_frame();
		repeat (16'(lw) + 16'(hw) + 6) @(negedge clk);
		rd(i2cm_pkg::IDX_STATUS, 8'h80, 8'h80);
		wr(i2cm_pkg::IDX_SHIFT, 8'hA5);
		repeat (400) @(negedge clk);
		chk(rx_byte, 8'hA5);
		wr(i2cm_pkg::IDX_CTL0, 8'hC0);
		repeat (10) @(negedge clk);
		wr(i2cm_pkg::IDX_CTL0, 8'h92);
		repeat (16'(lw) + 16'(hw) + 6) @(negedge clk);
		rd(i2cm_pkg::IDX_STATUS, 8'h80, 8'h80);
		wr(i2cm_pkg::IDX_CTL0, 8'h00);
		repeat (10) @(negedge clk);
		bus.free_data(int'($urandom_range(4, 1)));
		repeat (8) @(negedge clk);
		rd(i2cm_pkg::IDX_STATUS, 8'h0C, 8'h0C);
		wr(i2cm_pkg::IDX_FLAG, 8'h01);
		wr(i2cm_pkg::IDX_CTL0, 8'h90);
		bus.open_frame();
		wr(i2cm_pkg::IDX_CTL0, 8'h92);
		bus.close_frame();
		repeat (40) @(negedge clk);
		rd(i2cm_pkg::IDX_STATUS, 8'hAC, 8'h0C);
		chk(8'(irqs), 8'h02);
		print_verdict();
	end
endmodule : testbench
bind i2cm_master i2cm_assertions chk_i (.clk(clk), .srst(srst), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.serial_clock_pin_in(serial_clock_pin_in), .serial_clock_pin_oe_n(serial_clock_pin_oe_n),
	.serial_data_pin_in(serial_data_pin_in), .serial_data_pin_oe_n(serial_data_pin_oe_n),
	.transfer_interrupt_request(transfer_interrupt_request));
